// ### ast_pkg.sv
// Constants, register map and types for the sampling timing control block
package ast_pkg;
    // Clock rates and half-period divider of the converter clock
    localparam int unsigned SYS_CLK_HZ  = 40_000_000;
    localparam int unsigned CONV_CLK_HZ = 10_000_000;
    localparam int unsigned HALF_CYC    = SYS_CLK_HZ / (2 * CONV_CLK_HZ);
    localparam logic [3:0]  HDIV_MAX    = 4'(HALF_CYC - 1);
    // Sequencing times in converter half periods
    localparam logic [5:0]  TRIG_DLY_HT = 6'h05;  // 2.5 converter clocks
    localparam logic [5:0]  SEQ_GAP_HT  = 6'h02;  // 1 clock between pulses
    localparam logic [5:0]  SIM_GAP_HT  = 6'h04;  // 2 clocks between pulses
    localparam int          PIPE_W      = 10;
    localparam int          RES_A_TAP   = 7;      // 4 clocks after sampling
    localparam int          RES_B_TAP   = 9;      // 5 clocks after sampling
    // Register byte offsets
    localparam logic [7:0]  CTRL1_OFS   = 8'h00;
    localparam logic [7:0]  TRIG_OFS    = 8'h04;
    localparam logic [7:0]  CTRL3_OFS   = 8'h08;
    localparam logic [7:0]  CHSEL_OFS   = 8'h0C;
    localparam logic [7:0]  STAT_OFS    = 8'h10;
    localparam logic [7:0]  MASK_OFS    = 8'h14;
    localparam logic [7:0]  RESA_OFS    = 8'h18;
    localparam logic [7:0]  RESB_OFS    = 8'h1C;
    // Field positions and writable bits
    localparam int          ACQ_LSB     = 8;
    localparam int          CONT_BIT    = 4;
    localparam int          SAMPLING_MODE_SELECT_BIT   = 0;
    localparam int          PWR_BIT     = 5;
    localparam int          SOFT_BIT    = 0;
    localparam int          BUSY_BIT    = 8;
    localparam logic [31:0] CTRL1_WM    = 32'h0000_0F10;
    localparam logic [31:0] CTRL3_WM    = 32'h0000_00E1;
    localparam logic [31:0] CHSEL_WM    = 32'h0000_000F;
    localparam logic [31:0] IRQ_WM      = 32'h0000_0003;
    // Reset values
    localparam logic [31:0] CTRL1_RST   = 32'h0000_0000;
    localparam logic [31:0] CTRL3_RST   = 32'h0000_0000;
    localparam logic [31:0] CHSEL_RST   = 32'h0000_0000;
    localparam logic [1:0]  IRQ_RST     = 2'h0;
    // Sequencer states, Gray coded along the usual path
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_DELAY = 2'h1,
        ST_HOLD  = 2'h3,
        ST_GAP   = 2'h2
    } ast_state_t;
endpackage

// ### ast_top.sv
// Sampling sequencer, sample/hold timing and result posting for the converter
//
// The Wishbone slave port and the address map were left to the implementer.
module ast_top (
    input  wire logic        clk_i,        // System clock, 40 MHz
    input  wire logic        rst_i,        // Synchronous reset, high
    input  wire logic        wb_cyc_i,     // Bus cycle
    input  wire logic        wb_stb_i,     // Bus strobe
    input  wire logic        wb_we_i,      // Write enable
    input  wire logic [7:0]  wb_adr_i,     // Byte address
    input  wire logic [3:0]  wb_sel_i,     // Byte lanes
    input  wire logic [31:0] wb_dat_i,     // Write data
    output logic      [31:0] wb_dat_o,     // Read data
    output logic             wb_ack_o,     // Acknowledge
    output logic             irq_o,        // Level interrupt
    input  wire logic        pwm_trig_i,   // PWM event, one-cycle pulse
    input  wire logic        ext_start_i,  // External start pin
    input  wire logic [11:0] conv_a_i,     // Pipeline output, A side
    input  wire logic [11:0] conv_b_i,     // Pipeline output, B side
    output logic             conv_clk_o,   // Converter clock
    output logic             sh_a_o,       // Sample/hold pulse, A side
    output logic             sh_b_o,       // Sample/hold pulse, B side
    output logic      [2:0]  mux_a_o,      // A multiplexer index
    output logic      [2:0]  mux_b_o       // B multiplexer index
);
    // Per-byte merge of a write into a register; mask, status and trigger writes merge into zero
    function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return (old_v & ~m) | (new_v & m);
    endfunction

    logic [31:0]         ctrl1_r, ctrl3_r, chsel_r, dat_r;
    logic [1:0]          stat_r, mask_r, ev_d1_r, ev_d2_r;
    logic                ack_r, irq_r;
    logic                ext_m_r, ext_s_r, ext_d_r;
    logic [3:0]          hdiv_r;
    logic                cph_r;
    ast_pkg::ast_state_t state_r, state_nxt;
    logic [5:0]          cnt_r, cnt_nxt;
    logic                sh_a_r, sh_b_r, sh_nxt, fire;
    logic                run_sim_r;
    logic [3:0]          run_ch_r;
    logic [2:0]          mux_r;
    logic [ast_pkg::PIPE_W-1:0] pipe_r;
    logic [11:0]         res_a_r, res_b_r;

    // Bus decode; a write lands on the edge where ack is seen
    wire        req      = wb_cyc_i & wb_stb_i;
    wire        wr_take  = req & wb_we_i & ack_r;
    wire        sel_c1   = wb_adr_i == ast_pkg::CTRL1_OFS;
    wire        sel_tr   = wb_adr_i == ast_pkg::TRIG_OFS;
    wire        sel_c3   = wb_adr_i == ast_pkg::CTRL3_OFS;
    wire        sel_ch   = wb_adr_i == ast_pkg::CHSEL_OFS;
    wire        sel_st   = wb_adr_i == ast_pkg::STAT_OFS;
    wire        sel_mk   = wb_adr_i == ast_pkg::MASK_OFS;
    wire        sel_ra   = wb_adr_i == ast_pkg::RESA_OFS;
    wire        sel_rb   = wb_adr_i == ast_pkg::RESB_OFS;
    wire [31:0] wr_st    = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);

    // Control fields
    wire [3:0]  acq      = ctrl1_r[ast_pkg::ACQ_LSB +: 4];
    wire        cont     = ctrl1_r[ast_pkg::CONT_BIT];
    wire        sampling_mode_select    = ctrl3_r[ast_pkg::SAMPLING_MODE_SELECT_BIT];
    wire        pwr_en   = ctrl3_r[ast_pkg::PWR_BIT];
    wire        busy     = (state_r != ast_pkg::ST_IDLE) | (|pipe_r);
    wire        sh_any   = sh_a_r | sh_b_r;

    // Trigger sources; a trigger while busy is dropped
    wire        soft_trig = wr_take & sel_tr & wr_st[ast_pkg::SOFT_BIT];
    wire        ext_rise  = ext_s_r & ~ext_d_r;
    wire        trig_any  = pwm_trig_i | soft_trig | ext_rise;
    wire        trig_go   = trig_any & pwr_en & ~busy;

    // Half-period tick of the converter clock, restarted by a trigger
    wire        tick     = hdiv_r == ast_pkg::HDIV_MAX;
    wire [5:0]  hold_ht  = 6'(({2'h0, acq} + 6'h01) << 1);
    wire [5:0]  gap_ht   = run_sim_r ? ast_pkg::SIM_GAP_HT
                                     : ast_pkg::SEQ_GAP_HT;

    // Result moments are taps on the sample marker pipe
    wire        res_a_ev = tick & pipe_r[ast_pkg::RES_A_TAP];
    wire        res_b_ev = tick & pipe_r[ast_pkg::RES_B_TAP] & run_sim_r;
    wire [11:0] seq_dat  = run_ch_r[3] ? conv_b_i : conv_a_i;
    wire [1:0]  stat_clr = (wr_take & sel_st) ? wr_st[1:0] : 2'h0;
    wire [1:0]  stat_nxt = (stat_r & ~stat_clr) | ev_d2_r;

    // Read mux; unmapped offsets read zero
    wire [31:0] rdata =
        sel_c1 ? ctrl1_r :
        sel_c3 ? ctrl3_r :
        sel_ch ? chsel_r :
        sel_st ? {23'h0, busy, 6'h0, stat_r} :
        sel_mk ? {30'h0, mask_r} :
        sel_ra ? {20'h0, res_a_r} :
        sel_rb ? {20'h0, res_b_r} : 32'h0000_0000;

    // Bus slave: one wait state, ack drops after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req & ~ack_r;
            if (req & ~ack_r) begin
                dat_r <= rdata;
            end
        end
    end

    // Software registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1_r <= ast_pkg::CTRL1_RST;
            ctrl3_r <= ast_pkg::CTRL3_RST;
            chsel_r <= ast_pkg::CHSEL_RST;
            mask_r  <= ast_pkg::IRQ_RST;
        end else if (wr_take) begin
            if (sel_c1) ctrl1_r <= wmerge(ctrl1_r, wb_dat_i, wb_sel_i) & ast_pkg::CTRL1_WM;
            if (sel_c3) ctrl3_r <= wmerge(ctrl3_r, wb_dat_i, wb_sel_i) & ast_pkg::CTRL3_WM;
            if (sel_ch) chsel_r <= wmerge(chsel_r, wb_dat_i, wb_sel_i) & ast_pkg::CHSEL_WM;
            if (sel_mk) mask_r  <= wr_st[1:0];
        end
    end

    // Flags lag the result update by two cycles; set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_d1_r <= 2'h0;
            ev_d2_r <= 2'h0;
            stat_r  <= ast_pkg::IRQ_RST;
            irq_r   <= 1'b0;
        end else begin
            ev_d1_r <= {res_b_ev, res_a_ev};
            ev_d2_r <= ev_d1_r;
            stat_r  <= stat_nxt;
            irq_r   <= |(stat_nxt & mask_r);
        end
    end

    // Start pin passes two flops before the edge detector
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_m_r <= 1'b0;
            ext_s_r <= 1'b0;
            ext_d_r <= 1'b0;
        end else begin
            ext_m_r <= ext_start_i;
            ext_s_r <= ext_m_r;
            ext_d_r <= ext_s_r;
        end
    end

    // Converter clock divider, phase realigned to each accepted trigger
    always_ff @(posedge clk_i) begin
        if (rst_i || trig_go) begin
            hdiv_r <= 4'h0;
            cph_r  <= 1'b0;
        end else begin
            hdiv_r <= tick ? 4'h0 : hdiv_r + 4'h1;
            cph_r  <= cph_r ^ tick;
        end
    end

    // Sequencer: delay, hold pulse, gap; repeats while continuous is set
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_any;
        fire      = 1'b0;
        unique case (state_r)
            ast_pkg::ST_IDLE: begin
                if (trig_go) begin
                    state_nxt = ast_pkg::ST_DELAY;
                    cnt_nxt   = ast_pkg::TRIG_DLY_HT - 6'h01;
                end
            end
            ast_pkg::ST_DELAY: begin
                if (tick) begin
                    if (cnt_r == 6'h00) begin
                        state_nxt = ast_pkg::ST_HOLD;
                        cnt_nxt   = hold_ht - 6'h01;
                        sh_nxt    = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r - 6'h01;
                    end
                end
            end
            ast_pkg::ST_HOLD: begin
                if (tick) begin
                    if (cnt_r == 6'h00) begin
                        sh_nxt    = 1'b0;
                        fire      = 1'b1;
                        state_nxt = cont ? ast_pkg::ST_GAP : ast_pkg::ST_IDLE;
                        cnt_nxt   = gap_ht - 6'h01;
                    end else begin
                        cnt_nxt = cnt_r - 6'h01;
                    end
                end
            end
            ast_pkg::ST_GAP: begin
                if (tick) begin
                    if (cnt_r != 6'h00) begin
                        cnt_nxt = cnt_r - 6'h01;
                    end else if (cont) begin
                        state_nxt = ast_pkg::ST_HOLD;
                        cnt_nxt   = hold_ht - 6'h01;
                        sh_nxt    = 1'b1;
                    end else begin
                        state_nxt = ast_pkg::ST_IDLE;
                    end
                end
            end
        endcase
    end

    // Sequencer state; mode and channel are frozen for the whole run
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r   <= ast_pkg::ST_IDLE;
            cnt_r     <= 6'h00;
            run_sim_r <= 1'b0;
            run_ch_r  <= 4'h0;
            mux_r     <= 3'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            if (trig_go) begin
                run_sim_r <= sampling_mode_select;
                run_ch_r  <= chsel_r[3:0];
                mux_r     <= chsel_r[2:0];
            end
        end
    end

    // Pulse routing: one side in sequential mode, both in simultaneous
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh_a_r <= 1'b0;
            sh_b_r <= 1'b0;
        end else begin
            sh_a_r <= sh_nxt & (run_sim_r | ~run_ch_r[3]);
            sh_b_r <= sh_nxt & (run_sim_r | run_ch_r[3]);
        end
    end

    // Marker pipe; several samples may be in flight at short acquisition
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pipe_r <= '0;
        end else if (tick) begin
            pipe_r <= {pipe_r[ast_pkg::PIPE_W-2:0], fire};
        end
    end

    // Result registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_a_r <= 12'h000;
            res_b_r <= 12'h000;
        end else begin
            if (res_a_ev) res_a_r <= run_sim_r ? conv_a_i : seq_dat;
            if (res_b_ev) res_b_r <= conv_b_i;
        end
    end

    assign wb_dat_o   = dat_r;
    assign wb_ack_o   = ack_r;
    assign irq_o      = irq_r;
    assign conv_clk_o = cph_r;
    assign sh_a_o     = sh_a_r;
    assign sh_b_o     = sh_b_r;
    assign mux_a_o    = mux_r;
    assign mux_b_o    = mux_r;

    // Checks
    localparam int TRIG_CYC = 10;
    localparam int RES_A_CYC = 15;
    localparam int RES_B_CYC = 19;
    localparam int SEQ_GAP_CYC = 3;
    localparam int SIM_GAP_CYC = 7;
    logic [6:0] shlen_r;
    logic [5:0] hcap_r;
    always_ff @(posedge clk_i) begin
        shlen_r <= (rst_i || !sh_any) ? 7'h00 : shlen_r + 7'h01;
        if (!sh_any) hcap_r <= hold_ht;  // Acq may change mid-pulse
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_pulse_start;
        !sh_any ##1 sh_any;
    endsequence
    chk_trig_delay: assert property (
        trig_go |-> ##[TRIG_CYC:TRIG_CYC] s_pulse_start)
        else $error("sample pulse not 2.5 clocks after trigger");
    chk_pulse_width: assert property (
        $fell(sh_any) |-> shlen_r == 7'(int'(hcap_r) * ast_pkg::HALF_CYC))
        else $error("sample pulse width wrong");
    chk_res_a_time: assert property (
        $fell(sh_any) |-> ##[RES_A_CYC:RES_A_CYC] res_a_ev)
        else $error("first result not 4 clocks after sampling");
    chk_res_b_time: assert property (
        $fell(sh_b_r) && run_sim_r |-> ##[RES_B_CYC:RES_B_CYC] res_b_ev)
        else $error("B result not 5 clocks after sampling");
    chk_seq_period: assert property (
        $fell(sh_any) && !run_sim_r ##[SEQ_GAP_CYC:SEQ_GAP_CYC] cont |=> sh_any)
        else $error("sequential pulse period wrong");
    chk_sim_period: assert property (
        $fell(sh_any) && run_sim_r ##[SIM_GAP_CYC:SIM_GAP_CYC] cont |=> sh_any)
        else $error("simultaneous pulse period wrong");
    chk_flag_after: assert property (
        $rose(stat_r[0]) |-> $past(res_a_ev, 3))
        else $error("flag set without prior result update");
    chk_mode_route: assert property (
        sh_any |-> (run_sim_r ? (sh_a_r && sh_b_r) : (sh_a_r != sh_b_r)))
        else $error("sample pulse routed wrongly for mode");
    chk_power_gate: assert property (
        trig_any && !pwr_en && !busy |=> state_r == ast_pkg::ST_IDLE)
        else $error("conversion started without power enable");
    chk_bus_ack: assert property (
        req && !ack_r |=> ack_r ##1 !ack_r)
        else $error("bus ack not a single cycle after request");
endmodule

// ### ast_analog_model.sv
// Behavioural model of the analog inputs feeding the converter pipeline
module ast_analog_model (
    input  wire logic        clk_i,     // System clock
    input  wire logic        sh_a_i,    // A sample/hold pulse
    input  wire logic        sh_b_i,    // B sample/hold pulse
    input  wire logic [2:0]  mux_a_i,   // A channel index
    input  wire logic [2:0]  mux_b_i,   // B channel index
    output logic      [11:0] conv_a_o,  // A pipeline word
    output logic      [11:0] conv_b_o   // B pipeline word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sh_a_r   = 1'h0;
    logic        sh_b_r   = 1'h0;
    // Words start cleared so a result posted before any sample shows up wrong
    logic [11:0] word_a_r = 12'h000;
    logic [11:0] word_b_r = 12'h000;
    // Word frozen at the falling edge, so a late mux change cannot leak in
    always @(posedge clk_i) begin
        sh_a_r <= sh_a_i;
        sh_b_r <= sh_b_i;
        if (sh_a_r && !sh_a_i) word_a_r <= {4'hA, 5'h00, mux_a_i};
        if (sh_b_r && !sh_b_i) word_b_r <= {4'hB, 5'h00, mux_b_i};
    end
    assign conv_a_o = word_a_r;
    assign conv_b_o = word_b_r;
endmodule

// ### test_adc_sampling_timing_control.sv
// Self-checking bench for the sampling timing control block
module test_adc_sampling_timing_control;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic       md;
        logic [3:0] acq;
        logic [3:0] ch;
        logic [1:0] src;
        logic       cont;
        logic [7:0] dly;
    } ast_row_t;
    logic        clk_i       = 1'h0;
    logic        rst_i       = 1'h1;
    logic        wb_cyc_i    = 1'h0;
    logic        wb_stb_i    = 1'h0;
    logic        wb_we_i     = 1'h0;
    logic [7:0]  wb_adr_i    = 8'h00;
    logic [3:0]  wb_sel_i    = 4'h0;
    logic [31:0] wb_dat_i    = 32'h0;
    logic        pwm_trig_i  = 1'h0;
    logic        ext_start_i = 1'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, irq_o, sh_a_o, sh_b_o, conv_clk_o;
    logic [11:0] conv_a_i, conv_b_i;
    logic [2:0]  mux_a_o, mux_b_o;
    int          tick = 0;
    int          mismatches = 0;
    int          num_checks = 0;
    // Mode, count, channel, source, repeat, then irq delay after the pulse falls
    ast_row_t    rows [6] = '{'{1'h0, 4'h0, 4'h3, 2'h0, 1'h0, 8'h12},
                              '{1'h0, 4'hF, 4'hC, 2'h1, 1'h0, 8'h12},
                              '{1'h1, 4'h2, 4'h5, 2'h2, 1'h0, 8'h16},
                              '{1'h0, 4'h1, 4'h7, 2'h0, 1'h1, 8'h12},
                              '{1'h1, 4'h0, 4'h0, 2'h1, 1'h1, 8'h16},
                              '{1'h1, 4'hF, 4'hE, 2'h0, 1'h0, 8'h16}};
    logic [7:0]  wm_ofs [5] = '{ast_pkg::CTRL1_OFS, ast_pkg::CTRL3_OFS, ast_pkg::CHSEL_OFS,
                               ast_pkg::MASK_OFS, 8'h20};
    logic [31:0] wm_val [5] = '{ast_pkg::CTRL1_WM, ast_pkg::CTRL3_WM, ast_pkg::CHSEL_WM,
                               ast_pkg::IRQ_WM, 32'h0};

    ast_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
                   .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .pwm_trig_i, .ext_start_i,
                   .conv_a_i, .conv_b_i, .conv_clk_o, .sh_a_o, .sh_b_o, .mux_a_o, .mux_b_o);
    ast_analog_model u_analog (.clk_i, .sh_a_i(sh_a_o), .sh_b_i(sh_b_o), .mux_a_i(mux_a_o),
                               .mux_b_i(mux_b_o), .conv_a_o(conv_a_i), .conv_b_o(conv_b_i));

    // 40 MHz clock and a cycle count for latency measurements
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) tick <= tick + 1;

    task automatic stop_test();
        if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic give_up(input string nm);
        mismatches++;
        $display("MISMATCH %s expected event seen timeout", nm);
        stop_test();
    endtask
    // Classic single cycle; request held until ack is sampled at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q, output int tk);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 64) give_up("bus ack");
        end while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        tk = tick + 1;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        int tk;
        wb(1'h1, a, d, s, q, tk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        int tk;
        wb(1'h0, a, 32'h0, 4'hF, q, tk);
        chk(nm, e, q);
    endtask
    // Returns the tick of the take edge for the chosen trigger source
    task automatic fire(input logic [1:0] src, output int t0);
        logic [31:0] q;
        @(posedge clk_i);
        if (src == 2'h1) wb(1'h1, ast_pkg::TRIG_OFS, 32'h1, 4'h1, q, t0);
        else if (src == 2'h0) pwm_trig_i <= 1'h1;
        else ext_start_i <= 1'h1;
        if (src == 2'h2) t0 = tick + 4;
        if (src != 2'h1) @(posedge clk_i);
        if (src == 2'h0) t0 = tick + 1;
        pwm_trig_i <= 1'h0;
        if (src == 2'h2) repeat (3) @(posedge clk_i);
        ext_start_i <= 1'h0;
    endtask
    task automatic wait_for(input logic irq, input logic lvl, input string nm, output int t);
        logic v;
        for (int n = 0; n < 2000; n++) begin
            @(posedge clk_i);
            #1;
            v = irq ? irq_o : (sh_a_o | sh_b_o);
            if (v === lvl) begin
                t = tick;
                return;
            end
        end
        give_up(nm);
    endtask
    // No pulse for n cycles; the free-running converter clock flips once per half period
    task automatic quiet(input int n, input string nm);
        logic seen, prev;
        int   flips;
        seen  = 1'h0;
        prev  = 1'h0;
        flips = 0;
        for (int i = 0; i <= n; i++) begin
            @(posedge clk_i);
            #1;
            seen = seen | (sh_a_o !== 1'h0) | (sh_b_o !== 1'h0);
            if (i > 0 && conv_clk_o !== prev) flips++;
            prev = conv_clk_o;
        end
        chk(nm, 32'h0, {31'h0, seen});
        chk("conv clk flips", 32'(n / ast_pkg::HALF_CYC), 32'(flips));
    endtask
    task automatic idle();
        logic [31:0] q;
        int tk;
        for (int i = 0; i < 200; i++) begin
            wb(1'h0, ast_pkg::STAT_OFS, 32'h0, 4'hF, q, tk);
            if (q[ast_pkg::BUSY_BIT] === 1'h0) return;
        end
        give_up("busy");
    endtask

    // Main sequence: reset values, table of conversions, then refusals and masking
    initial begin
        ast_row_t r;
        int t0, t1, t2, t3;
        logic [31:0] ea;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int a = 0; a < 36; a += 4) rd(8'(a), 32'h0, "reset value");
        chk("irq reset", 32'h0, {31'h0, irq_o});
        for (int i = 0; i < 5; i++) begin
            wr(wm_ofs[i], 32'hFFFF_FFFF, 4'hF);
            rd(wm_ofs[i], wm_val[i], "writable bits");
            wr(wm_ofs[i], 32'h0, 4'hF);
        end
        for (int i = 0; i < 6; i++) begin
            r = rows[i];
            wr(ast_pkg::CTRL1_OFS, {20'h0, r.acq, 3'h0, r.cont, 4'h0}, 4'hF);
            wr(ast_pkg::CTRL3_OFS, {24'h0, 7'h70, r.md}, 4'hF);
            wr(ast_pkg::CHSEL_OFS, {28'h0, r.ch}, 4'hF);
            wr(ast_pkg::MASK_OFS, {30'h0, r.md, ~r.md}, 4'hF);
            fire(r.src, t0);
            wait_for(1'h0, 1'h1, "sh rise", t1);
            chk("sh delay", 32'd10, t1 - t0);
            chk("mux a", {29'h0, r.ch[2:0]}, {29'h0, mux_a_o});
            chk("mux b", {29'h0, r.ch[2:0]}, {29'h0, mux_b_o});
            if (r.md) chk("sh b high", 32'h1, {31'h0, sh_b_o});
            wait_for(1'h0, 1'h0, "sh fall", t2);
            chk("sh width", 4 * (1 + r.acq), t2 - t1);
            if (r.cont) begin
                wait_for(1'h0, 1'h1, "sh again", t3);
                chk("sh period", 4 * (2 + r.md + r.acq), t3 - t1);
                wr(ast_pkg::CTRL1_OFS, 32'h0, 4'hF);
            end
            wait_for(1'h1, 1'h1, "irq", t3);
            chk("irq delay", {24'h0, r.dly}, t3 - t2);
            idle();
            rd(ast_pkg::STAT_OFS, {30'h0, r.md, 1'h1}, "status");
            ea = {23'h005, r.ch[3] & ~r.md, 5'h00, r.ch[2:0]}; // B word for a B-side channel in sequential mode
            rd(ast_pkg::RESA_OFS, ea, "result a");
            if (r.md) rd(ast_pkg::RESB_OFS, {20'h0, 9'h160, r.ch[2:0]}, "result b");
            wr(ast_pkg::STAT_OFS, 32'h3, 4'hF);
            rd(ast_pkg::STAT_OFS, 32'h0, "status cleared");
            chk("irq cleared", 32'h0, {31'h0, irq_o});
        end
        // Refused triggers: power off, then a trigger write without byte lane 0
        wr(ast_pkg::CTRL3_OFS, 32'h0, 4'hF);
        fire(2'h0, t0);
        quiet(40, "power off");
        wr(ast_pkg::CTRL3_OFS, 32'hE0, 4'hF);
        wr(ast_pkg::MASK_OFS, 32'h1, 4'hF);
        wr(ast_pkg::TRIG_OFS, 32'h1, 4'hE);
        quiet(40, "lane off");
        // A second trigger during a conversion is dropped
        fire(2'h0, t0);
        wait_for(1'h0, 1'h1, "sh rise", t1);
        fire(2'h2, t0);
        wait_for(1'h0, 1'h0, "sh fall", t2);
        fire(2'h0, t0); // Results still pending, so dropped too
        quiet(60, "busy drop");
        idle();
        // Masking gates the line, the sticky flag stays until a written one clears it
        wr(ast_pkg::MASK_OFS, 32'h0, 4'hF);
        rd(ast_pkg::STAT_OFS, 32'h1, "flag kept");
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wr(ast_pkg::STAT_OFS, 32'h1, 4'h0);
        wr(ast_pkg::MASK_OFS, 32'h1, 4'hF);
        rd(ast_pkg::STAT_OFS, 32'h1, "lane gated clear");
        chk("irq unmasked", 32'h1, {31'h0, irq_o});
        wr(ast_pkg::STAT_OFS, 32'h1, 4'hF);
        rd(ast_pkg::STAT_OFS, 32'h0, "flag cleared");
        chk("irq low", 32'h0, {31'h0, irq_o});
        stop_test();
    end
endmodule
